// File: rwb_ctrl.sv
// Purpose: Wake-up gating, reset merging and brownout handling
// Assumes: Configuration bits come from logic on clk; pins are asynchronous
// Notes: Mode entry is requested by the core through lp_enter with lp_mode
`timescale 1ns/1ps
`default_nettype none
`include "rwb_defines.svh"
module rwb_ctrl #(
    parameter int IRQ_W  = 32,
    parameter int PIN_W  = 8,
    parameter int PER_W  = 8,
    parameter int BOD_LV = 4
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    input  wire logic               por_n,
    input  wire logic               external_reset_pin_n,
    input  wire logic               wake_pin,
    input  wire logic               lp_enter,
    input  wire rwb_pkg::rwb_mode_t lp_mode,
    input  wire logic [IRQ_W-1:0]   irq_pending,
    input  wire logic [IRQ_W-1:0]   core_interrupt_controller_en,
    input  wire logic [PIN_W-1:0]   pin_irq,
    input  wire logic [PIN_W-1:0]   pin_start_logic_enable,
    input  wire logic [PER_W-1:0]   periph_irq,
    input  wire logic [PER_W-1:0]   periph_start_logic_enable,
    input  wire logic [PIN_W-1:0]   pin_irq_ctrl_en,
    input  wire logic [PER_W-1:0]   periph_irq_ctrl_en,
    input  wire logic               pin_function_enable_reg_reset,
    input  wire logic               deep_powerdown_control_reg_wake,
    input  wire logic               deep_powerdown_control_reg_reset,
    input  wire logic               deep_powerdown_control_reg_lposc_en,
    input  wire logic               deep_powerdown_control_reg_lposc_dpd,
    input  wire logic               self_wake_timeout,
    input  wire logic [BOD_LV-1:0]  brownout_below,
    input  wire logic [1:0]         brownout_irq_level,
    input  wire logic [1:0]         brownout_rst_level,
    input  wire logic               brownout_control_reg_irq_en,
    input  wire logic               brownout_control_reg_rst_en,
    input  wire logic               sleep_power_config_reg_bod_on,
    input  wire logic               sleep_power_config_reg_watchdog_oscillator_on,
    input  wire logic               windowed_watchdog_running,
    input  wire logic               watchdog_mode_reg_irq_en,
    input  wire logic               watchdog_mode_reg_rst_en,
    input  wire logic               watchdog_irq,
    input  wire logic               watchdog_timeout,
    input  wire logic [2:0]         periph_wdt_idx,
    input  wire logic [2:0]         periph_bod_idx,
    output logic                    chip_reset,
    output logic                    core_clk_en,
    output logic                    periph_clk_en,
    output logic                    fro_on,
    output logic                    flash_init,
    output logic                    brownout_irq,
    output logic                    brownout_status,
    output logic                    irq_present,
    output logic                    in_low_power,
    output logic [31:0]             boot_fetch_addr
);
    import rwb_pkg::*;

    logic        rpin_s1, rpin_s2, wpin_s1, wpin_s2, por_s1, por_s2;
    logic [BOD_LV-1:0] bod_s1, bod_s2;
    logic [1:0]  pulse_cnt;
    logic        pin_rst_req;
    rwb_state_t  state;
    rwb_mode_t   mode;
    logic [1:0]  clkon_cnt;
    logic        bod_irq_lvl, bod_rst_lvl, deep, dpd;
    logic        wake_sleep, wake_deep, wake_dpd, wake_any;
    logic        bod_wake_ok, wdt_wake_ok, rst_any;
    rwb_rst_if   rif ();

    // Two-stage synchronisers for pins and the analog comparators
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rpin_s1 <= 1'b1;
            rpin_s2 <= 1'b1;
            wpin_s1 <= 1'b0;
            wpin_s2 <= 1'b0;
            por_s1  <= 1'b0;
            por_s2  <= 1'b0;
            bod_s1  <= '0;
            bod_s2  <= '0;
        end else if (clk_en) begin
            rpin_s1 <= external_reset_pin_n;
            rpin_s2 <= rpin_s1;
            wpin_s1 <= wake_pin;
            wpin_s2 <= wpin_s1;
            por_s1  <= por_n;
            por_s2  <= por_s1;
            bod_s1  <= brownout_below;
            bod_s2  <= bod_s1;
        end
    end

    // Qualify a low reset pin for the minimum pulse width
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_cnt <= 2'h0;
        end else if (clk_en) begin
            if (rpin_s2) begin
                pulse_cnt <= 2'h0;
            end else if (pulse_cnt != 2'(`RWB_PIN_PULSE_CYC)) begin
                pulse_cnt <= pulse_cnt + 2'h1;
            end
        end
    end

    assign dpd  = (state == RWB_ST_LOWPOWER) && (mode == RWB_MODE_DEEP_PD);
    assign deep = (state == RWB_ST_LOWPOWER) &&
                  (mode == RWB_MODE_DEEP_SLEEP || mode == RWB_MODE_POWER_DOWN);

    // Reset pin counts only when its function is enabled for the mode
    assign pin_rst_req = (pulse_cnt == 2'(`RWB_PIN_PULSE_CYC)) &&
        (dpd ? deep_powerdown_control_reg_reset
             : pin_function_enable_reg_reset);

    // Brownout level selection for interrupt and reset
    assign bod_irq_lvl = bod_s2[brownout_irq_level];
    assign bod_rst_lvl = bod_s2[brownout_rst_level] && brownout_control_reg_rst_en;
    assign bod_wake_ok = !deep || sleep_power_config_reg_bod_on;
    assign wdt_wake_ok = !deep || sleep_power_config_reg_watchdog_oscillator_on;

    // Merge all reset sources; low-power qualifications for brownout and watchdog
    assign rst_any = !por_s2 || pin_rst_req ||
        (bod_rst_lvl && bod_wake_ok && !dpd) ||
        (watchdog_timeout && windowed_watchdog_running &&
         watchdog_mode_reg_rst_en && wdt_wake_ok && !dpd);
    assign rif.request = rst_any;

    rwb_rst_stretch u_stretch (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .rif    (rif)
    );

    assign chip_reset      = rif.chip_reset;
    assign flash_init      = rif.chip_reset;
    assign boot_fetch_addr = `RWB_BOOT_VECTOR;

    // Brownout interrupt and polled status registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            brownout_irq    <= 1'b0;
            brownout_status <= 1'b0;
        end else if (clk_en) begin
            brownout_irq    <= bod_irq_lvl && brownout_control_reg_irq_en;
            brownout_status <= bod_irq_lvl;
        end
    end

    // Wake qualification per mode
    assign wake_sleep = |(irq_pending & core_interrupt_controller_en);
    assign wake_deep  = |(pin_irq & pin_start_logic_enable & pin_irq_ctrl_en) ||
        |(periph_irq & periph_start_logic_enable & periph_irq_ctrl_en &
          ~(PER_W'(1) << periph_wdt_idx) & ~(PER_W'(1) << periph_bod_idx)) ||
        (brownout_irq && periph_start_logic_enable[periph_bod_idx] &&
         periph_irq_ctrl_en[periph_bod_idx] && sleep_power_config_reg_bod_on) ||
        (watchdog_irq && windowed_watchdog_running && watchdog_mode_reg_irq_en &&
         periph_start_logic_enable[periph_wdt_idx] &&
         periph_irq_ctrl_en[periph_wdt_idx] && sleep_power_config_reg_watchdog_oscillator_on);
    assign wake_dpd = (wpin_s2 && deep_powerdown_control_reg_wake) ||
        (self_wake_timeout && deep_powerdown_control_reg_lposc_en &&
         deep_powerdown_control_reg_lposc_dpd);
    assign wake_any = (mode == RWB_MODE_SLEEP) ? wake_sleep :
                      (mode == RWB_MODE_DEEP_PD) ? wake_dpd : wake_deep;

    // Power mode sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state     <= RWB_ST_RUN;
            mode      <= RWB_MODE_RUN;
            clkon_cnt <= 2'h0;
        end else if (clk_en) begin
            if (rif.chip_reset) begin
                state <= RWB_ST_RUN;
                mode  <= RWB_MODE_RUN;
            end else begin
                case (state)
                    RWB_ST_RUN: begin
                        if (lp_enter && lp_mode != RWB_MODE_RUN) begin
                            state <= RWB_ST_LOWPOWER;
                            mode  <= lp_mode;
                        end
                    end
                    RWB_ST_LOWPOWER: begin
                        if (wake_any) begin
                            state     <= RWB_ST_CLKON;
                            clkon_cnt <= 2'(`RWB_CLKON_WAIT_CYC);
                        end
                    end
                    RWB_ST_CLKON: begin
                        if (clkon_cnt == 2'h1) begin
                            state <= RWB_ST_PRESENT;
                        end
                        clkon_cnt <= clkon_cnt - 2'h1;
                    end
                    RWB_ST_PRESENT: begin
                        state <= RWB_ST_RUN;
                        mode  <= RWB_MODE_RUN;
                    end
                    default: begin
                        state <= RWB_ST_RUN;
                    end
                endcase
            end
        end
    end

    // Clock gates: sleep stops only the core, deeper modes stop more
    assign core_clk_en   = (state != RWB_ST_LOWPOWER) && !rif.chip_reset;
    assign periph_clk_en = !((state == RWB_ST_LOWPOWER) && (mode != RWB_MODE_SLEEP));
    assign fro_on        = rif.chip_reset || !((state == RWB_ST_LOWPOWER) &&
        (mode == RWB_MODE_POWER_DOWN || mode == RWB_MODE_DEEP_PD));
    assign irq_present   = (state == RWB_ST_PRESENT);
    assign in_low_power  = (state == RWB_ST_LOWPOWER);

    sequence s_wake;
        (state == RWB_ST_LOWPOWER) && wake_any && !rif.chip_reset && clk_en;
    endsequence
    sequence s_clocks_then_irq;
        core_clk_en && !irq_present;
    endsequence

    property p_wake_order;
        @(posedge clk) disable iff (reset)
        (s_wake ##0 (mode == RWB_MODE_SLEEP)) |=> s_clocks_then_irq;
    endproperty
    a_wake_order: assert property (p_wake_order)
        else $error("irq presented before clocks restored");

    property p_sleep_core_only;
        @(posedge clk) disable iff (reset)
        (in_low_power && mode == RWB_MODE_SLEEP) |-> (!core_clk_en && periph_clk_en);
    endproperty
    a_sleep_core_only: assert property (p_sleep_core_only)
        else $error("sleep gated more than the core");

    property p_sleep_wake;
        @(posedge clk) disable iff (reset)
        (in_low_power && mode == RWB_MODE_SLEEP && clk_en && !rif.chip_reset &&
         !wake_sleep) |=> in_low_power;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep left without enabled interrupt");

    property p_pin_rst;
        @(posedge clk) disable iff (reset)
        (clk_en && pin_rst_req) |=> chip_reset;
    endproperty
    a_pin_rst: assert property (p_pin_rst)
        else $error("qualified pin low did not reset");

    property p_por;
        @(posedge clk) disable iff (reset)
        !por_s2 |-> chip_reset && flash_init;
    endproperty
    a_por: assert property (p_por)
        else $error("power-on reset not merged");

    property p_dpd_pin;
        @(posedge clk) disable iff (reset)
        (dpd && !deep_powerdown_control_reg_wake && !self_wake_timeout && clk_en
         && !rif.chip_reset) |=> in_low_power;
    endproperty
    a_dpd_pin: assert property (p_dpd_pin)
        else $error("deep power-down left without enabled wake");

    property p_bod_status;
        @(posedge clk) disable iff (reset)
        clk_en |=> (brownout_status == $past(bod_irq_lvl));
    endproperty
    a_bod_status: assert property (p_bod_status)
        else $error("brownout status does not follow level");

    property p_bod_irq;
        @(posedge clk) disable iff (reset)
        (clk_en && !brownout_control_reg_irq_en) |=> !brownout_irq;
    endproperty
    a_bod_irq: assert property (p_bod_irq)
        else $error("brownout irq while disabled");

    property p_reset_run;
        @(posedge clk) disable iff (reset)
        (clk_en && rif.chip_reset) |=> (state == RWB_ST_RUN) && fro_on;
    endproperty
    a_reset_run: assert property (p_reset_run)
        else $error("reset did not return to run on oscillator");

    // Unpowered detector must not reset the chip in deep modes
    property p_bod_rst_unpowered;
        @(posedge clk) disable iff (reset)
        (deep && !sleep_power_config_reg_bod_on && por_s2 && !pin_rst_req &&
         !watchdog_timeout) |-> !rif.request;
    endproperty
    a_bod_rst_unpowered: assert property (p_bod_rst_unpowered)
        else $error("brownout reset with detector unpowered");

    // Deep power-down ignores the reset pin unless enabled for it
    property p_dpd_pin_rst;
        @(posedge clk) disable iff (reset)
        (dpd && !deep_powerdown_control_reg_reset && por_s2) |-> !rif.request;
    endproperty
    a_dpd_pin_rst: assert property (p_dpd_pin_rst)
        else $error("reset request in deep power-down while disabled");
endmodule // rwb_ctrl
`default_nettype wire

// File: rwb_defines.svh
// Purpose: Constants for the reset, wake-up and brownout controller
// Assumes: Included by its bare name
// Notes: Time figures in ns, pin pulse count derived from the 40 MHz clock
`ifndef RWB_DEFINES_SVH
`define RWB_DEFINES_SVH
`define RWB_CLK_PERIOD_NS    25
`define RWB_PIN_PULSE_NS     50
`define RWB_PIN_PULSE_CYC    ((`RWB_PIN_PULSE_NS + `RWB_CLK_PERIOD_NS - 1) / `RWB_CLK_PERIOD_NS)
`define RWB_RST_STRETCH_CYC  4
`define RWB_BOOT_VECTOR      32'h0000_0000
`define RWB_CLKON_WAIT_CYC   2
`endif

// File: rwb_pkg.sv
// Purpose: Types for the reset, wake-up and brownout controller
// Assumes: Nothing
// Notes: Power modes and wake sequencer states
package rwb_pkg;
    typedef enum logic [2:0] {
        RWB_MODE_RUN, RWB_MODE_SLEEP, RWB_MODE_DEEP_SLEEP,
        RWB_MODE_POWER_DOWN, RWB_MODE_DEEP_PD
    } rwb_mode_t;
    typedef enum logic [2:0] {
        RWB_ST_RUN, RWB_ST_LOWPOWER, RWB_ST_CLKON, RWB_ST_PRESENT
    } rwb_state_t;
endpackage

// File: rwb_rst_if.sv
// Purpose: Carries the combined reset request to the reset stretcher
// Assumes: One clock domain
// Notes: Request in, synchronous reset out
`timescale 1ns/1ps
`default_nettype none
interface rwb_rst_if;
    logic request;
    logic chip_reset;
    modport ctrl (output request, input chip_reset);
    modport stretch (input request, output chip_reset);
endinterface
`default_nettype wire

// File: rwb_rst_stretch.sv
// Purpose: Holds chip reset while any source is active, then releases it
// Assumes: Request is already synchronous to clk
// Notes: Release comes a fixed count of cycles after the last request
`timescale 1ns/1ps
`default_nettype none
`include "rwb_defines.svh"
module rwb_rst_stretch (
    input  wire logic   clk,
    input  wire logic   reset,
    input  wire logic   clk_en,
    rwb_rst_if.stretch  rif
);
    import rwb_pkg::*;
    logic [3:0] hold_cnt;

    // Count down after the last request; reset stays until zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_cnt <= 4'(`RWB_RST_STRETCH_CYC);
        end else if (clk_en) begin
            if (rif.request) begin
                hold_cnt <= 4'(`RWB_RST_STRETCH_CYC);
            end else if (hold_cnt != 4'h0) begin
                hold_cnt <= hold_cnt - 4'h1;
            end
        end
    end

    assign rif.chip_reset = rif.request || (hold_cnt != 4'h0);

    // A request reloads the stretch counter whenever clk_en is high
    property p_hold;
        @(posedge clk) disable iff (reset)
        (clk_en && rif.request) |=> rif.chip_reset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("chip reset dropped after request");

    // Reset outlasts the request that caused it
    property p_release;
        @(posedge clk) disable iff (reset)
        (clk_en && $past(clk_en) && $fell(rif.request)) |-> rif.chip_reset;
    endproperty
    a_release: assert property (p_release)
        else $error("chip reset released with request");
endmodule // rwb_rst_stretch
`default_nettype wire

// File: rwb_core_model.sv
// Purpose: Core side of the controller: pending interrupts and the self-wake timer
// Assumes: Driven from the bench on clk; one clock domain
// Notes: A pending interrupt is taken by the core when it is presented
`timescale 1ns/1ps
`default_nettype none
module rwb_core_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        raise,
    input  wire logic [4:0]  idx,
    input  wire logic        irq_present,
    input  wire logic        run_timer,
    input  wire logic        lposc_en,
    output logic [31:0]      irq_pending,
    output logic             self_wake_timeout
);
    logic       raise_q;
    logic [2:0] cnt;

    // Pending bit set on a new request, cleared when the core takes it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_pending <= 32'h0;
            raise_q     <= 1'h0;
        end else begin
            raise_q <= raise;
            if (irq_present) begin
                irq_pending <= 32'h0;
            end else if (raise && !raise_q) begin
                irq_pending <= 32'h1 << idx;
            end
        end
    end

    // Timer runs only once started and clocked from the low-power oscillator
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt <= 3'h0;
        end else if (!run_timer) begin
            cnt <= 3'h0;
        end else if (lposc_en && cnt != 3'h4) begin
            cnt <= cnt + 3'h1;
        end
    end

    assign self_wake_timeout = (cnt == 3'h4); // Stays high until the timer is stopped
endmodule // rwb_core_model
`default_nettype wire

// File: reset_wakeup_brownout_ctrl_tb.sv
// Purpose: Self-checking bench for the wake-up, reset and brownout controller
// Assumes: Default widths of the controller; clk_en high except in the freeze case
// Notes: Each case enters its low-power mode (run cases stay in run), applies sources, then notes wake and reset outcome
`timescale 1ns/1ps
`default_nettype none
module reset_wakeup_brownout_ctrl_tb;
    import rwb_pkg::*;
    // Case word: mode, expected {wake, reset}, source code
    localparam logic [31:0] CASES [24] = '{
        32'h12000003, 32'h10000001, 32'h12800003,
        32'h2200001C, 32'h20000014,
        32'h320000E0, 32'h30000060,
        32'h22000300, 32'h20000100,
        32'h42000C00, 32'h40000400,
        32'h42007000, 32'h40003000,
        32'h01018000, 32'h00008000, 32'h11018000,
        32'h01020000, 32'h010400A0, 32'h01080000,
        32'h41108000,
        32'h22600000, 32'h20200000,
        32'h310400A0, 32'h30040020};
    logic clk, reset, por_n, external_reset_pin_n, wake_pin, lp_enter, raise, run_timer;
    logic obs, watch, woke, rs, clk_en, periph_clk_en;
    logic [1:0] lvl;
    rwb_mode_t lp_mode;
    logic [31:0] irq_pending, core_interrupt_controller_en, boot_fetch_addr, rnd;
    logic [7:0] pin_irq, pin_start_logic_enable, pin_irq_ctrl_en;
    logic [7:0] periph_irq, periph_start_logic_enable, periph_irq_ctrl_en;
    logic pin_function_enable_reg_reset, deep_powerdown_control_reg_wake, self_wake_timeout;
    logic deep_powerdown_control_reg_reset, deep_powerdown_control_reg_lposc_en;
    logic deep_powerdown_control_reg_lposc_dpd, brownout_control_reg_irq_en;
    logic [3:0] brownout_below;
    logic brownout_control_reg_rst_en, sleep_power_config_reg_bod_on;
    logic sleep_power_config_reg_watchdog_oscillator_on, windowed_watchdog_running, watchdog_mode_reg_irq_en;
    logic watchdog_mode_reg_rst_en, watchdog_irq, watchdog_timeout, chip_reset, core_clk_en;
    logic fro_on, flash_init, brownout_irq, brownout_status, irq_present, in_low_power;
    logic [4:0] k;
    logic [1:0] notes [$];
    int err_count, total_checks;

    rwb_ctrl dut_u (.clk, .reset, .clk_en, .por_n, .external_reset_pin_n, .wake_pin,
        .lp_enter, .lp_mode, .irq_pending, .core_interrupt_controller_en, .pin_irq,
        .pin_start_logic_enable, .periph_irq, .periph_start_logic_enable, .pin_irq_ctrl_en,
        .periph_irq_ctrl_en, .pin_function_enable_reg_reset, .deep_powerdown_control_reg_wake,
        .deep_powerdown_control_reg_reset, .deep_powerdown_control_reg_lposc_en,
        .deep_powerdown_control_reg_lposc_dpd, .self_wake_timeout, .brownout_below,
        .brownout_irq_level(lvl), .brownout_rst_level(lvl), .brownout_control_reg_irq_en,
        .brownout_control_reg_rst_en, .sleep_power_config_reg_bod_on,
        .sleep_power_config_reg_watchdog_oscillator_on, .windowed_watchdog_running, .watchdog_mode_reg_irq_en,
        .watchdog_mode_reg_rst_en, .watchdog_irq, .watchdog_timeout, .periph_wdt_idx(3'h0),
        .periph_bod_idx(3'h1), .chip_reset, .core_clk_en, .periph_clk_en, .fro_on,
        .flash_init, .brownout_irq, .brownout_status, .irq_present, .in_low_power,
        .boot_fetch_addr);

    rwb_core_model model_u (.clk, .reset, .raise, .idx(k), .irq_present, .run_timer,
        .lposc_en(deep_powerdown_control_reg_lposc_en), .irq_pending, .self_wake_timeout);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %0t: %s", $time, msg);
            err_count++;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Map a source code onto the configuration levels and pins
    task automatic set_cfg(input logic [23:0] c);
        raise = c[0];
        core_interrupt_controller_en = c[1] ? (rnd | (32'h1 << k)) : (rnd & ~(32'h1 << k));
        pin_irq = {7'h0, c[2]};
        pin_start_logic_enable = {7'h0, c[3]};
        pin_irq_ctrl_en = {7'h0, c[4]};
        brownout_below = {4{c[5]}} & (4'h1 << lvl); // Only the selected level trips
        periph_irq = {5'h0, c[21], c[5], c[8]};
        periph_start_logic_enable = {5'h0, c[22], c[6], c[8]};
        periph_irq_ctrl_en = {5'h0, c[22], c[6], c[8]};
        brownout_control_reg_irq_en = c[6];
        sleep_power_config_reg_bod_on = c[7];
        windowed_watchdog_running = c[8] | c[17];
        watchdog_mode_reg_irq_en = c[8];
        watchdog_irq = c[8];
        sleep_power_config_reg_watchdog_oscillator_on = c[9];
        wake_pin = c[10];
        deep_powerdown_control_reg_wake = c[11];
        run_timer = c[12];
        deep_powerdown_control_reg_lposc_en = c[13];
        deep_powerdown_control_reg_lposc_dpd = c[14];
        external_reset_pin_n = ~c[15];
        pin_function_enable_reg_reset = c[16];
        watchdog_timeout = c[17];
        watchdog_mode_reg_rst_en = c[17];
        brownout_control_reg_rst_en = c[18];
        por_n = ~c[19];
        deep_powerdown_control_reg_reset = c[20];
    endtask

    task automatic wait_rst_low();
        int n;
        n = 0;
        while (chip_reset !== 1'h0 && n < 100) begin
            @(posedge clk);
            #2 n++;
        end
        if (chip_reset !== 1'h0) begin
            $display("ERROR %0t: reset never released", $time);
            err_count++;
            complete_run();
        end
        check(boot_fetch_addr, 32'h0, "boot fetch address");
        check(32'(fro_on), 32'h1, "free-running oscillator off");
    endtask

    // Enter the mode, apply the sources, note the outcome, then reset
    task automatic run_case(input logic [31:0] w);
        rwb_mode_t m;
        m = rwb_mode_t'(w[30:28]);
        k = rnd[4:0];
        lvl = rnd[6:5];
        rnd = lfsr(rnd);
        watch = 1'h1;
        if (m != RWB_MODE_RUN) begin
            lp_mode = m;
            lp_enter = 1'h1;
            @(posedge clk);
            #2 lp_enter = 1'h0;
            check(32'(in_low_power), 32'h1, "low power not entered");
            check(32'(core_clk_en), 32'h0, "core clock still running");
            check(32'(periph_clk_en), 32'(m == RWB_MODE_SLEEP), "peripheral clock gating");
        end
        set_cfg(w[23:0]);
        // Freeze case: the controller must stay in low power while the clock enable is low
        if (w[23]) begin
            clk_en = 1'h0;
            repeat (10) @(posedge clk);
            #2 check(32'(in_low_power), 32'h1, "state moved while frozen");
            clk_en = 1'h1;
        end
        repeat (20) @(posedge clk);
        #2 notes.push_back(w[25:24]);
        obs = 1'h1;
        if (w[6]) begin
            check(32'(brownout_irq), 32'h1, "brownout request missing");
            check(32'(brownout_status), 32'h1, "brownout status missing");
        end
        @(posedge clk);
        #2 obs = 1'h0;
        watch = 1'h0;
        set_cfg(24'h0);
        reset = 1'h1;
        repeat (2) @(posedge clk);
        #2 reset = 1'h0;
        wait_rst_low();
        $display("case done mode %0d code %h", m, w[23:0]);
    endtask

    // Watch the outputs and compare each outcome with the oldest note
    always @(posedge clk) begin
        if (watch && irq_present === 1'h1) begin
            woke = 1'h1;
            check(32'(core_clk_en), 32'h1, "clock off when presented");
        end
        if (watch && chip_reset === 1'h1) begin
            rs = 1'h1;
            check(32'(fro_on & flash_init), 32'h1, "oscillator or flash init missing");
        end
        if (obs) begin
            check({30'h0, woke, rs}, {30'h0, notes.pop_front()}, "wake or reset outcome");
            woke = 1'h0;
            rs = 1'h0;
        end
    end

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        reset = 1'h1;
        lp_enter = 1'h0;
        lp_mode = RWB_MODE_RUN;
        obs = 1'h0;
        watch = 1'h0;
        clk_en = 1'h1;
        lvl = 2'h0;
        woke = 1'h0;
        rs = 1'h0;
        rnd = 32'h74370622;
        k = 5'h0;
        err_count = 0;
        total_checks = 0;
        set_cfg(24'h0);
        repeat (8) @(posedge clk);
        #2 reset = 1'h0;
        wait_rst_low();
        for (int i = 0; i < 24; i++) begin
            run_case(CASES[i]);
        end
        complete_run();
    end
endmodule // reset_wakeup_brownout_ctrl_tb
`default_nettype wire
